// File: core/cale_defs.svh
// cale_defs.svh: constants of the arithmetic, logic and branch executor
// Function
// RL1: add-with-carry sums accumulator, file and carry into destination
// RL2: add-with-carry sets negative, wrap, carry, half carry, zero flags
// RL3: destination bit 0 writes accumulator, 1 writes the file register back
// RL4: bank-access bit 0 uses the fast access bank, 1 uses bank pointer
// RL5: AND-literal ands accumulator with low byte into accumulator, N and Z
// RL6: AND-file ands accumulator with file register, sets N and Z, one cycle
// RL7: branch-on-carry branches only when carry is 1, signed 8-bit offset
// RL8: taken branch loads PC+2+2n and idles one cycle; not taken takes one
// RL9: branch-on-negative branches only when negative is 1, flags unchanged
// RL10: branch-on-no-carry branches only when carry is 0, flags unchanged
// RL11: bit-clear clears selected bit 0 to 7 of file byte, flags unchanged
// RL12: other opcodes pass to remaining decode, no flag or register changed
`ifndef CALE_DEFS_SVH
`define CALE_DEFS_SVH

`define CALE_OFF_INSTR   8'h00
`define CALE_OFF_ACCUM   8'h04
`define CALE_OFF_BANK    8'h08
`define CALE_OFF_STATUS  8'h0C
`define CALE_OFF_PC      8'h10
`define CALE_OFF_FADDR   8'h14
`define CALE_OFF_FDATA   8'h18
`define CALE_OFF_STATE   8'h1C

`define CALE_FLAG_C      0
`define CALE_FLAG_HC     1
`define CALE_FLAG_Z      2
`define CALE_FLAG_SW     3
`define CALE_FLAG_N      4

`define CALE_OPC6_ADDC   6'h08
`define CALE_OPC6_ANDF   6'h05
`define CALE_OPC8_ANDL   8'h0B
`define CALE_OPC4_BCLR   4'h9
`define CALE_OPC8_BRCS   8'hE2
`define CALE_OPC8_BRNG   8'hE6
`define CALE_OPC8_BRCC   8'hE3

`define CALE_ACC_RST     8'h00
`define CALE_BANK_RST    4'h0
`define CALE_STAT_RST    5'h00
`define CALE_PC_RST      21'h000000
`define CALE_FPTR_RST    12'h000
`define CALE_PC_STEP     21'h000002
`define CALE_ACCESS_LO   4'h0
`define CALE_ACCESS_HI   4'hF

`define CALE_Q_FIRST     2'h0
`define CALE_Q_READ      2'h1
`define CALE_Q_LAST      2'h3

`endif

// File: core/cale_pkg.sv
// cale_pkg.sv: types of the arithmetic, logic and branch executor
package cale_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_NOP  = 2'b10
   } cale_state_t;

   typedef enum logic [1:0] {
      ALU_ADDC = 2'b00,
      ALU_AND  = 2'b01,
      ALU_BCLR = 2'b10
   } cale_aluop_t;

endpackage : cale_pkg

// File: core/cale_alu.sv
// cale_alu.sv: byte datapath for add with carry, and, bit clear
`timescale 1ns/100ps
module cale_alu (
   input  wire cale_pkg::cale_aluop_t op,
   input  wire logic [7:0]            acc,
   input  wire logic [7:0]            opnd,
   input  wire logic                  cin,
   input  wire logic [2:0]            bpos,
   output logic [7:0]                 res,
   output logic                       cout,
   output logic                       dcout,
   output logic                       ovout
);
   import cale_pkg::*;

   logic [8:0] sum9;
   logic [4:0] lo5;
   logic       c7in;
   logic [7:0] bmask;

   assign sum9  = {1'b0, acc} + {1'b0, opnd} + {8'h00, cin};
   assign lo5   = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
   // signed wrap is carry into bit 7 differing from carry out
   assign c7in  = acc[7] ^ opnd[7] ^ sum9[7];
   assign bmask = 8'h01 << bpos;

   assign res   = (op == ALU_ADDC) ? sum9[7:0] :
                  (op == ALU_AND)  ? (acc & opnd) :
                  (op == ALU_BCLR) ? (opnd & ~bmask) : 8'h00;
   assign cout  = sum9[8];
   assign dcout = lo5[4];
   assign ovout = c7in ^ sum9[8];

endmodule : cale_alu

// File: core/cale_exec.sv
// cale_exec.sv: executor of add, and, bit clear and flag branches
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/100ps
`include "cale_defs.svh"
module cale_exec (
   input  wire logic        CLK_SYS,
   input  wire logic        SYS_RST,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [31:0] WB_DAT_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic        WB_WE_I,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   output logic [31:0]      WB_DAT_O,
   output logic             WB_ACK_O,
   output logic             BUSY,
   output logic             PASS_VALID,
   output logic [15:0]      PASS_WORD,
   output logic [20:0]      PASS_PC
);
   import cale_pkg::*;

   cale_state_t st_q;
   cale_state_t st_d;
   logic [1:0]  qph_q;
   logic [15:0] ir_q;
   logic [7:0]  acc_q;
   logic [7:0]  rd_q;
   logic [3:0]  bank_q;
   logic [4:0]  stat_q;
   logic [4:0]  stat_d;
   logic [20:0] pc_q;
   logic [11:0] fptr_q;
   logic [7:0]  mem [0:4095];
   logic        ack_q;
   logic        busy_q;
   logic        pass_q;
   logic [31:0] dat_q;
   logic [15:0] pw_q;
   logic [20:0] ppc_q;

   // bus decode
   logic        wb_req;
   logic        wb_wr;
   logic        idle;
   logic [31:0] bmask;
   logic        hit_instr;
   logic        hit_acc;
   logic        hit_bank;
   logic        hit_stat;
   logic        hit_pc;
   logic        hit_fptr;
   logic        hit_fdat;
   logic        hit_state;
   logic        issue;
   logic        bw_acc;
   logic        bw_bank;
   logic        bw_stat;
   logic        bw_pc;
   logic        bw_fptr;
   logic        bw_fdat;
   logic [31:0] m_pc;
   logic [31:0] m_fptr;
   logic [31:0] rdata;

   assign wb_req    = WB_CYC_I & WB_STB_I & ~ack_q;
   assign wb_wr     = wb_req & WB_WE_I;
   assign idle      = (st_q == ST_IDLE);
   assign bmask     = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                       {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
   assign hit_instr = (WB_ADR_I == `CALE_OFF_INSTR);
   assign hit_acc   = (WB_ADR_I == `CALE_OFF_ACCUM);
   assign hit_bank  = (WB_ADR_I == `CALE_OFF_BANK);
   assign hit_stat  = (WB_ADR_I == `CALE_OFF_STATUS);
   assign hit_pc    = (WB_ADR_I == `CALE_OFF_PC);
   assign hit_fptr  = (WB_ADR_I == `CALE_OFF_FADDR);
   assign hit_fdat  = (WB_ADR_I == `CALE_OFF_FDATA);
   assign hit_state = (WB_ADR_I == `CALE_OFF_STATE);

   // state writes while busy are dropped so software cannot race a commit
   assign issue   = wb_wr & hit_instr & idle & (&WB_SEL_I[1:0]);
   assign bw_acc  = wb_wr & hit_acc & idle & WB_SEL_I[0];
   assign bw_bank = wb_wr & hit_bank & idle & WB_SEL_I[0];
   assign bw_stat = wb_wr & hit_stat & idle & WB_SEL_I[0];
   assign bw_pc   = wb_wr & hit_pc & idle;
   assign bw_fptr = wb_wr & hit_fptr & idle;
   assign bw_fdat = wb_wr & hit_fdat & idle & WB_SEL_I[0];
   assign m_pc    = ({11'h000, pc_q} & ~bmask) | (WB_DAT_I & bmask);
   assign m_fptr  = ({20'h00000, fptr_q} & ~bmask) | (WB_DAT_I & bmask);

   assign rdata = hit_instr ? {16'h0000, ir_q} :
                  hit_acc   ? {24'h000000, acc_q} :
                  hit_bank  ? {28'h0000000, bank_q} :
                  hit_stat  ? {27'h0000000, stat_q} :
                  hit_pc    ? {11'h000, pc_q} :
                  hit_fptr  ? {20'h00000, fptr_q} :
                  hit_fdat  ? {24'h000000, mem[fptr_q]} :
                  hit_state ? {30'h00000000, st_q} : 32'h00000000;

   // instruction decode
   logic        is_addc;
   logic        is_andf;
   logic        is_andl;
   logic        is_bclr;
   logic        is_brcs;
   logic        is_brng;
   logic        is_brcc;
   logic        is_br;
   logic        known;
   logic        dst_file;
   logic        abit;
   logic [7:0]  fld;
   logic [3:0]  bank_sel;
   logic [11:0] faddr;
   logic        taken;
   logic [20:0] br_off;
   logic [20:0] br_tgt;
   logic        commit;
   logic        wr_acc_ex;
   logic        wr_mem_ex;

   assign is_addc  = (ir_q[15:10] == `CALE_OPC6_ADDC);
   assign is_andf  = (ir_q[15:10] == `CALE_OPC6_ANDF);
   assign is_andl  = (ir_q[15:8] == `CALE_OPC8_ANDL);
   assign is_bclr  = (ir_q[15:12] == `CALE_OPC4_BCLR);
   assign is_brcs  = (ir_q[15:8] == `CALE_OPC8_BRCS);
   assign is_brng  = (ir_q[15:8] == `CALE_OPC8_BRNG);
   assign is_brcc  = (ir_q[15:8] == `CALE_OPC8_BRCC);
   assign is_br    = is_brcs | is_brng | is_brcc;
   assign known    = is_addc | is_andf | is_andl | is_bclr | is_br;
   assign dst_file = ir_q[9];
   assign abit     = ir_q[8];
   assign fld      = ir_q[7:0];

   // RL4: access bank or bank pointer
   assign bank_sel = abit ? bank_q :
                     (fld[7] ? `CALE_ACCESS_HI : `CALE_ACCESS_LO);
   assign faddr    = {bank_sel, fld};

   // RL7: carry set, RL9: negative set, RL10: carry clear
   assign taken = (is_brcs & stat_q[`CALE_FLAG_C]) |
                  (is_brng & stat_q[`CALE_FLAG_N]) |
                  (is_brcc & ~stat_q[`CALE_FLAG_C]);

   // RL8: twice the signed offset
   assign br_off = {{12{fld[7]}}, fld, 1'b0};
   assign br_tgt = pc_q + `CALE_PC_STEP + br_off;

   // results land in the fourth phase, the write phase
   assign commit = (st_q == ST_EXEC) & (qph_q == `CALE_Q_LAST);

   // RL3: destination bit routes result
   assign wr_acc_ex = commit &
                      (is_andl | ((is_addc | is_andf) & ~dst_file));
   assign wr_mem_ex = commit &
                      (is_bclr | ((is_addc | is_andf) & dst_file));

   // datapath
   cale_aluop_t alu_op;
   logic [7:0]  alu_b;
   logic [7:0]  alu_res;
   logic        alu_c;
   logic        alu_hc;
   logic        alu_sw;

   // RL5: literal operand from the low byte
   assign alu_b  = is_andl ? fld : rd_q;
   assign alu_op = is_addc ? ALU_ADDC : (is_bclr ? ALU_BCLR : ALU_AND);

   // RL1: accumulator plus file plus carry
   cale_alu u_alu (
      .op    (alu_op),
      .acc   (acc_q),
      .opnd  (alu_b),
      .cin   (stat_q[`CALE_FLAG_C]),
      .bpos  (ir_q[11:9]),
      .res   (alu_res),
      .cout  (alu_c),
      .dcout (alu_hc),
      .ovout (alu_sw)
   );

   always_comb begin
      stat_d = stat_q;
      if (bw_stat) begin
         stat_d = WB_DAT_I[4:0];
      end else if (commit & is_addc) begin
         // RL2: all five flags from sum
         stat_d[`CALE_FLAG_C]  = alu_c;
         stat_d[`CALE_FLAG_HC] = alu_hc;
         stat_d[`CALE_FLAG_SW] = alu_sw;
         stat_d[`CALE_FLAG_N]  = alu_res[7];
         stat_d[`CALE_FLAG_Z]  = (alu_res == 8'h00);
      end else if (commit & (is_andl | is_andf)) begin
         // RL6: only negative and zero
         stat_d[`CALE_FLAG_N]  = alu_res[7];
         stat_d[`CALE_FLAG_Z]  = (alu_res == 8'h00);
      end
   end

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_IDLE: begin
            if (issue) begin
               st_d = ST_EXEC;
            end
         end
         ST_EXEC: begin
            // RL8: taken branch adds an idle cycle
            if (qph_q == `CALE_Q_LAST) begin
               st_d = (is_br & taken) ? ST_NOP : ST_IDLE;
            end
         end
         ST_NOP: begin
            if (qph_q == `CALE_Q_LAST) begin
               st_d = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         st_q   <= ST_IDLE;
         qph_q  <= `CALE_Q_FIRST;
         busy_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         qph_q  <= idle ? `CALE_Q_FIRST : qph_q + 2'h1;
         busy_q <= (st_d != ST_IDLE);
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         ir_q <= 16'h0000;
      end else if (issue) begin
         ir_q <= WB_DAT_I[15:0];
      end
   end

   // file read in the second phase
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         rd_q <= 8'h00;
      end else if ((st_q == ST_EXEC) && (qph_q == `CALE_Q_READ)) begin
         rd_q <= mem[faddr];
      end
   end

   // RL11: cleared bit written back
   always_ff @(posedge CLK_SYS) begin
      if (wr_mem_ex) begin
         mem[faddr] <= alu_res;
      end else if (bw_fdat) begin
         mem[fptr_q] <= WB_DAT_I[7:0];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         acc_q  <= `CALE_ACC_RST;
         bank_q <= `CALE_BANK_RST;
         stat_q <= `CALE_STAT_RST;
         fptr_q <= `CALE_FPTR_RST;
      end else begin
         acc_q  <= wr_acc_ex ? alu_res :
                   (bw_acc ? WB_DAT_I[7:0] : acc_q);
         bank_q <= bw_bank ? WB_DAT_I[3:0] : bank_q;
         stat_q <= stat_d;
         fptr_q <= bw_fptr ? m_fptr[11:0] : fptr_q;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         pc_q <= `CALE_PC_RST;
      end else if (bw_pc) begin
         pc_q <= m_pc[20:0];
      end else if (commit & is_br & taken) begin
         pc_q <= br_tgt;
      end else if (commit & known) begin
         pc_q <= pc_q + `CALE_PC_STEP;
      end
   end

   // RL12: foreign opcode handed onward
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         pass_q <= 1'b0;
         pw_q   <= 16'h0000;
         ppc_q  <= `CALE_PC_RST;
      end else begin
         pass_q <= commit & ~known;
         if (commit & ~known) begin
            pw_q  <= ir_q;
            ppc_q <= pc_q;
         end
      end
   end

   // unmapped offsets still ack, reading zero
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         ack_q <= wb_req;
         if (wb_req & ~WB_WE_I) begin
            dat_q <= rdata;
         end
      end
   end

   assign WB_ACK_O   = ack_q;
   assign WB_DAT_O   = dat_q;
   assign BUSY       = busy_q;
   assign PASS_VALID = pass_q;
   assign PASS_WORD  = pw_q;
   assign PASS_PC    = ppc_q;

   // checks
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (SYS_RST);

   logic [8:0] chk_sum;
   assign chk_sum = {1'b0, acc_q} + {1'b0, rd_q} +
                    {8'h00, stat_q[`CALE_FLAG_C]};

   sequence s_nop4;
      (st_q == ST_NOP) [*4];
   endsequence

   sequence s_exec4;
      (st_q == ST_EXEC) [*4];
   endsequence

   a_addc_sum: assert property ( // RL1
      commit & is_addc & ~dst_file |=> acc_q == $past(chk_sum[7:0]))
      else $error("add with carry sum wrong");

   a_addc_carry: assert property ( // RL2
      commit & is_addc |=> stat_q[`CALE_FLAG_C] == $past(chk_sum[8])
         && stat_q[`CALE_FLAG_Z] == ($past(chk_sum[7:0]) == 8'h00))
      else $error("add with carry flags wrong");

   a_dest_file: assert property ( // RL3
      commit & (is_addc | is_andf) & dst_file |=> $stable(acc_q))
      else $error("file destination touched accumulator");

   a_bank_pick: assert property ( // RL4
      (st_q == ST_EXEC) & abit |-> faddr[11:8] == bank_q)
      else $error("bank pointer not used");

   a_andl_result: assert property ( // RL5
      commit & is_andl |=> acc_q == ($past(acc_q) & $past(ir_q[7:0]))
         && stat_q[`CALE_FLAG_C] == $past(stat_q[`CALE_FLAG_C]))
      else $error("and literal wrong");

   a_andf_cycle: assert property ( // RL6
      issue && WB_DAT_I[15:10] == `CALE_OPC6_ANDF
         |=> s_exec4 ##1 st_q == ST_IDLE)
      else $error("and file not one cycle");

   a_branch_take: assert property ( // RL8
      commit & is_br & taken
         |=> pc_q == $past(br_tgt) ##0 s_nop4 ##1 st_q == ST_IDLE)
      else $error("taken branch timing or target wrong");

   a_carry_gate: assert property ( // RL7
      commit & is_brcs & ~stat_q[`CALE_FLAG_C]
         |=> pc_q == $past(pc_q) + `CALE_PC_STEP && st_q == ST_IDLE)
      else $error("carry branch taken without carry");

   a_neg_flags: assert property ( // RL9
      commit & is_brng |=> $stable(stat_q))
      else $error("negative branch changed flags");

   a_nocarry_gate: assert property ( // RL10
      commit & is_brcc |-> taken == ~stat_q[`CALE_FLAG_C]
         ##1 $stable(stat_q))
      else $error("no carry branch wrong");

   a_bclr_bit: assert property ( // RL11
      commit & is_bclr |-> alu_res[ir_q[11:9]] == 1'b0
         && wr_mem_ex ##1 $stable(stat_q))
      else $error("bit clear wrong");

   a_pass_on: assert property ( // RL12
      commit & ~known |=> PASS_VALID && $stable(acc_q)
         && $stable(stat_q) && $stable(pc_q))
      else $error("foreign opcode not passed cleanly");

endmodule : cale_exec

// File: sim/cale_exec_test.sv
// cale_exec_test.sv: self-checking bench for the executor
`timescale 1ns/100ps
`include "cale_defs.svh"
module cale_exec_test;
   import cale_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        we = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dat_o;
   logic        ack;
   logic        busy;
   logic        pv;
   logic [15:0] pw;
   logic [20:0] ppc;
   int          fail_count = 0;
   int          checks = 0;
   int          cyc_n = 0;
   int          busy_tot = 0;
   int          pass_tot = 0;
   logic [15:0] rs = 16'h0035;
   logic [15:0] r1, r2, r3, ins;
   logic [31:0] q;

   cale_exec i_dut (
      .CLK_SYS(clk), .SYS_RST(rst), .WB_ADR_I(adr), .WB_DAT_I(dat),
      .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_DAT_O(dat_o), .WB_ACK_O(ack), .BUSY(busy), .PASS_VALID(pv),
      .PASS_WORD(pw), .PASS_PC(ppc)
   );

   always #2 clk = ~clk;

   // whole run needs a few thousand cycles; a hang stops here
   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      if (busy === 1'b1) busy_tot <= busy_tot + 1;
      if (pv === 1'b1) pass_tot <= pass_tot + 1;
      if (cyc_n == 20000) begin
         fail_count++;
         final_report();
      end
   end

   function automatic logic [15:0] nx();
      rs = {rs[14:0], rs[15] ^ rs[13] ^ rs[12] ^ rs[10]};
      return rs;
   endfunction : nx

   task automatic final_report;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report

   task automatic chk(input string nm, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // request held until ack is sampled high, then released
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rq);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      do @(posedge clk); while (ack !== 1'b1);
      rq = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr

   task automatic run_case(input logic [7:0] acc, input logic [4:0] st,
                           input logic [3:0] bk, input logic [7:0] fv,
                           input logic [20:0] pc, input logic [15:0] ic);
      logic [11:0] fa;
      logic [8:0]  s;
      logic [7:0]  r, ea, ef;
      logic [4:0]  es;
      logic [20:0] epc;
      logic [7:0]  o8;
      int          b0, p0, tk, fo, n;
      o8 = ic[15:8];
      fa = ic[8] ? {bk, ic[7:0]} : {(ic[7] ? 4'hF : 4'h0), ic[7:0]};
      wr(`CALE_OFF_ACCUM, {24'h0, acc});
      wr(`CALE_OFF_BANK, {28'h0, bk});
      wr(`CALE_OFF_STATUS, {27'h0, st});
      wr(`CALE_OFF_PC, {11'h0, pc});
      wr(`CALE_OFF_FADDR, {20'h0, fa});
      wr(`CALE_OFF_FDATA, {24'h0, fv});
      ea = acc; ef = fv; es = st; epc = pc + 21'h2; tk = 0; fo = 0;
      if (ic[15:10] == `CALE_OPC6_ADDC) begin
         s = acc + fv + st[0];
         r = s[7:0];
         es[0] = s[8];
         es[1] = ({1'b0, acc[3:0]} + fv[3:0] + st[0]) > 5'h0F;
         es[3] = (acc[7] == fv[7]) && (r[7] != acc[7]);
         es[2] = (r == 8'h00);
         es[4] = r[7];
         if (ic[9]) ef = r; else ea = r;
      end else if (ic[15:10] == `CALE_OPC6_ANDF ||
                   o8 == `CALE_OPC8_ANDL) begin
         r = acc & ((o8 == `CALE_OPC8_ANDL) ? ic[7:0] : fv);
         es[2] = (r == 8'h00);
         es[4] = r[7];
         if (ic[9] && o8 != `CALE_OPC8_ANDL) ef = r; else ea = r;
      end else if (ic[15:12] == `CALE_OPC4_BCLR) begin
         ef[ic[11:9]] = 1'b0;
      end else if (o8 == `CALE_OPC8_BRCS || o8 == `CALE_OPC8_BRNG ||
                   o8 == `CALE_OPC8_BRCC) begin
         tk = (o8 == `CALE_OPC8_BRCS && st[0]) ||
              (o8 == `CALE_OPC8_BRNG && st[4]) ||
              (o8 == `CALE_OPC8_BRCC && !st[0]);
         if (tk) epc = pc + 21'h2 + {{12{ic[7]}}, ic[7:0], 1'b0};
      end else begin
         fo = 1;
         epc = pc;
      end
      b0 = busy_tot;
      p0 = pass_tot;
      wr(`CALE_OFF_INSTR, {16'h0, ic});
      // write while busy must be dropped
      wr(`CALE_OFF_ACCUM, {24'h0, ~acc});
      n = 0;
      while (busy !== 1'b0 && n < 40) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      chk("busy cycles", tk ? 8 : 4, busy_tot - b0);
      chk("pass pulses", fo, pass_tot - p0);
      if (fo) begin
         chk("pass word", {16'h0, ic}, {16'h0, pw});
         chk("pass pc", {11'h0, pc}, {11'h0, ppc});
      end
      bus(1'b0, `CALE_OFF_ACCUM, 32'h0, q);
      chk("accum", {24'h0, ea}, q);
      bus(1'b0, `CALE_OFF_STATUS, 32'h0, q);
      chk("status", {27'h0, es}, q);
      bus(1'b0, `CALE_OFF_PC, 32'h0, q);
      chk("pc", {11'h0, epc}, q);
      bus(1'b0, `CALE_OFF_FDATA, 32'h0, q);
      chk("file byte", {24'h0, ef}, q);
   endtask : run_case

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int a = 4; a <= 32; a += 4) begin
         // file memory has no reset value, so it is written first
         if (a != 24) begin
            bus(1'b0, a[7:0], 32'h0, q);
            chk("reset value", 32'h0, q);
         end
      end
      wr(`CALE_OFF_FDATA, 32'h0000_00A5);
      bus(1'b0, `CALE_OFF_FDATA, 32'h0, q);
      chk("file byte", 32'h0000_00A5, q);
      wr(8'h20, 32'hFFFF_FFFF);
      bus(1'b0, 8'h20, 32'h0, q);
      chk("unmapped", 32'h0, q);
      $display("reset and map test done");
      run_case(8'hFF, 5'h01, 4'h0, 8'h00, 21'h100, 16'h2010);
      run_case(8'h7F, 5'h01, 4'h3, 8'h00, 21'h100, 16'h2390);
      run_case(8'hA3, 5'h1F, 4'h0, 8'h00, 21'h040, 16'h0B5F);
      run_case(8'h17, 5'h00, 4'h5, 8'hC2, 21'h040, 16'h1742);
      run_case(8'h00, 5'h01, 4'h0, 8'h00, 21'h400, 16'hE280);
      run_case(8'h00, 5'h00, 4'h0, 8'h00, 21'h400, 16'hE37F);
      run_case(8'h00, 5'h10, 4'h0, 8'h00, 21'h400, 16'hE6FF);
      run_case(8'h00, 5'h00, 4'h2, 8'hFF, 21'h010, 16'h9E85);
      run_case(8'h11, 5'h0A, 4'h0, 8'h33, 21'h020, 16'h0F15);
      $display("directed test done");
      for (int i = 0; i < 64; i++) begin
         r1 = nx();
         r2 = nx();
         r3 = nx();
         case (r1[2:0])
            3'd0: ins = {`CALE_OPC6_ADDC, r2[9:0]};
            3'd1: ins = {`CALE_OPC6_ANDF, r2[9:0]};
            3'd2: ins = {`CALE_OPC8_ANDL, r2[7:0]};
            3'd3: ins = {`CALE_OPC4_BCLR, r2[11:0]};
            3'd4: ins = {`CALE_OPC8_BRCS, r2[7:0]};
            3'd5: ins = {`CALE_OPC8_BRNG, r2[7:0]};
            3'd6: ins = {`CALE_OPC8_BRCC, r2[7:0]};
            default: ins = r2;
         endcase
         run_case(r3[7:0], r1[15:11], r3[11:8], r2[15:8] ^ r3[15:8],
                  {r3, r1[7:4], 1'b0}, ins);
      end
      $display("random test done");
      final_report();
   end
endmodule : cale_exec_test
